// ===== rtl/compact_timer_pkg.sv
// Purpose: shared constants for the compact 10-bit timer
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes: each register is one aligned word, data in the low byte
package compact_timer_pkg;
  localparam int CNT_W = 10;
  localparam int RP_W = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // ==========================================================
  // register byte addresses
  localparam logic [7:0] OFS_CTL0 = 8'h00;
  localparam logic [7:0] OFS_CTL1 = 8'h04;
  localparam logic [7:0] OFS_CNT_LOW = 8'h08;
  localparam logic [7:0] OFS_CNT_HIGH = 8'h0C;
  localparam logic [7:0] OFS_CMPA_LOW = 8'h10;
  localparam logic [7:0] OFS_CMPA_HIGH = 8'h14;
  localparam logic [7:0] RST_CTL0 = 8'h00;
  localparam logic [7:0] RST_CTL1 = 8'h00;
  localparam logic [9:0] RST_CMPA = 10'h000;
  localparam logic [9:0] CNT_MAX = 10'h3FF;
  // ==========================================================
  // timer_control_0 fields
  localparam int B_PAUSE = 7;
  localparam int B_CKSEL_HI = 6;
  localparam int B_CKSEL_LO = 4;
  localparam int B_ON = 3;
  localparam int B_RP_HI = 2;
  // timer_control_1 fields
  localparam int B_MODE_HI = 7;
  localparam int B_MODE_LO = 6;
  localparam int B_IO_HI = 5;
  localparam int B_IO_LO = 4;
  localparam int B_OC = 3;
  localparam int B_INV = 2;
  localparam int B_SWAP = 1;
  localparam int B_CLRSEL = 0;
  // ==========================================================
  // encodings
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;
  localparam logic [1:0] IO_NONE = 2'h0;
  localparam logic [1:0] IO_LOW = 2'h1;
  localparam logic [1:0] IO_HIGH = 2'h2;
  localparam logic [1:0] IO_TOGGLE = 2'h3;
  localparam logic [1:0] IO_PWM_INACT = 2'h0;
  localparam logic [1:0] IO_PWM_ACT = 2'h1;
  localparam logic [1:0] IO_PWM_WAVE = 2'h2;
  localparam logic [2:0] CK_SYS4 = 3'h0;
  localparam logic [2:0] CK_SYS = 3'h1;
  localparam logic [2:0] CK_H16 = 3'h2;
  localparam logic [2:0] CK_H64 = 3'h3;
  localparam logic [2:0] CK_SUB0 = 3'h4;
  localparam logic [2:0] CK_SUB1 = 3'h5;
  localparam logic [2:0] CK_EXT_RISE = 3'h6;
  localparam logic [2:0] CK_EXT_FALL = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : compact_timer_pkg

// ===== rtl/count_tick_gen.sv
// Purpose: counting clock selection as one-cycle ticks
// Assumes: high and sub clock ticks and the pin are synchronous to aclk
// Notes: system/4, high/16 and high/64 come from free prescalers
`timescale 1ns/1ps
`default_nettype none
module count_tick_gen (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // selection and sources
  input wire logic [2:0] clock_select,
  input wire logic high_clk_tick,
  input wire logic sub_clk_tick,
  input wire logic external_count_clock_pin,
  // tick out
  output logic tick
);
  import compact_timer_pkg::*;
  logic [1:0] sys_div;
  logic [5:0] high_div;
  logic pin_q;
  // ==========================================================
  // prescalers and pin edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_div <= 2'h0;
      high_div <= 6'h00;
      pin_q <= 1'b0;
    end else begin
      sys_div <= sys_div + 2'h1;
      if (high_clk_tick) begin
        high_div <= high_div + 6'h01;
      end
      pin_q <= external_count_clock_pin;
    end
  end
  always_comb begin
    unique case (clock_select) // RULE5
      CK_SYS4: tick = (sys_div == 2'h3);
      CK_SYS: tick = 1'b1;
      CK_H16: tick = high_clk_tick && (high_div[3:0] == 4'hF);
      CK_H64: tick = high_clk_tick && (high_div == 6'h3F);
      CK_SUB0, CK_SUB1: tick = sub_clk_tick;
      CK_EXT_RISE: tick = external_count_clock_pin && !pin_q;
      CK_EXT_FALL: tick = !external_count_clock_pin && pin_q;
    endcase
  end
endmodule : count_tick_gen
`default_nettype wire

// ===== rtl/output_shaper.sv
// Purpose: drives the true and inverted timer output pins
// Assumes: match pulse and pwm level arrive from the counter core
// Notes: timer/counter mode and the undefined mode hold the pin
`timescale 1ns/1ps
`default_nettype none
module output_shaper (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic [1:0] operating_mode_select,
  input wire logic [1:0] output_function_select,
  input wire logic output_initial_level,
  input wire logic output_invert,
  input wire logic on_rise,
  input wire logic a_match,
  input wire logic pwm_active,
  // pins
  output logic timer_output_pin,
  output logic timer_output_pin_inverted
);
  import compact_timer_pkg::*;
  logic level;
  logic next_level;
  logic drive;
  logic next_pin;
  // ==========================================================
  // level selection
  always_comb begin
    next_level = level;
    drive = 1'b1;
    if (operating_mode_select == MODE_CMP) begin
      if (on_rise) begin
        next_level = output_initial_level; // RULE7 RULE16
      end else if (a_match) begin
        unique case (output_function_select) // RULE13 RULE17
          IO_NONE: next_level = level;
          IO_LOW: next_level = 1'b0;
          IO_HIGH: next_level = 1'b1;
          IO_TOGGLE: next_level = !level;
        endcase
      end
    end else if (operating_mode_select == MODE_PWM) begin
      // active level chosen by output_initial_level
      if (on_rise || output_function_select == IO_PWM_ACT ||
          (output_function_select == IO_PWM_WAVE && pwm_active)) begin
        next_level = output_initial_level; // RULE14 RULE16
      end else begin
        next_level = !output_initial_level; // RULE14
      end
    end else begin
      drive = 1'b0; // RULE12
    end
    next_pin = drive ? (next_level ^ output_invert) : timer_output_pin; // RULE22
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level <= 1'b0;
      timer_output_pin <= 1'b0;
      timer_output_pin_inverted <= 1'b1;
    end else begin
      level <= next_level;
      timer_output_pin <= next_pin;
      timer_output_pin_inverted <= !next_pin; // RULE18
    end
  end
endmodule : output_shaper
`default_nettype wire

// ===== rtl/compact_timer.sv
// Purpose: compact 10-bit count-up timer with AXI4-Lite registers
// Assumes: one clock, synchronous active-low reset, synchronous pins
// Notes: low bytes go through one shared 8-bit buffer
//
// Overview of operation
// [RULE1] a 10-bit up-counter advances on each selected counting tick
// [RULE2] comparator P checks top three bits, comparator A all ten
// [RULE3] software clears counter only by on rising; hardware clears on match
// [RULE4] pause bit high halts counting and holds; low resumes from it
// [RULE5] clock select picks system/4, system, high/16, high/64, sub, pin edges
// [RULE6] counter on low stops and holds; its rising edge zeroes the count
// [RULE7] on rising restores the output pin to its initial level
// [RULE8] period match every k times 128 clocks, zero means 1024
// [RULE9] clear select low: period match clears; period zero runs to overflow
// [RULE10] mode field: 00 compare, 01 undefined, 10 pwm, 11 timer
// [RULE11] software switches the timer off before changing mode
// [RULE12] timer mode leaves the pin undriven by the timer logic
// [RULE13] compare mode A match: none, low, high or toggle
// [RULE14] pwm mode: force inactive, force active, waveform, undefined
// [RULE15] software changes the output function only while off
// [RULE16] initial level bit sets start level or pwm active level
// [RULE17] high or low actions equal to initial level show no change
// [RULE18] second pin always carries the inverse of the primary pin
// [RULE19] count readable as low/high pair; compare A read/write pair
// [RULE20] clear select high: A match clears; ignored in pwm mode
// [RULE21] swap bit exchanges period and duty roles of P and A
// [RULE22] invert bit inverts the primary pin except in timer mode
// [RULE23] low bytes via buffer; high access moves buffer contents
// [RULE24] one-cycle event pulse per A match; per P match only in pwm mode or with clear select low
`timescale 1ns/1ps
`default_nettype none
module compact_timer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [compact_timer_pkg::ADDR_W-1:0] awaddr,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [compact_timer_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [compact_timer_pkg::ADDR_W-1:0] araddr,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [compact_timer_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  // clock sources
  input wire logic high_clk_tick,
  input wire logic sub_clk_tick,
  input wire logic external_count_clock_pin,
  // output pins
  output logic timer_output_pin,
  output logic timer_output_pin_inverted,
  // match events
  output logic event_a,
  output logic event_p
);
  import compact_timer_pkg::*;
  logic [7:0] timer_control_0;
  logic [7:0] timer_control_1;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] compare_a_value;
  logic [7:0] byte_buffer;
  logic on_q;
  logic aw_hold;
  logic w_hold;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_byte_q;
  logic w_lane_q;
  // ==========================================================
  // control field views
  logic pause_ctl;
  logic [2:0] clock_select;
  logic counter_on;
  logic [RP_W-1:0] period_compare_value;
  logic [1:0] operating_mode_select;
  logic [1:0] output_function_select;
  logic output_initial_level;
  logic output_invert;
  logic pwm_role_swap;
  logic clear_source_select;
  assign pause_ctl = timer_control_0[B_PAUSE];
  assign clock_select = timer_control_0[B_CKSEL_HI:B_CKSEL_LO];
  assign counter_on = timer_control_0[B_ON];
  assign period_compare_value = timer_control_0[B_RP_HI:0];
  assign operating_mode_select = timer_control_1[B_MODE_HI:B_MODE_LO];
  assign output_function_select = timer_control_1[B_IO_HI:B_IO_LO];
  assign output_initial_level = timer_control_1[B_OC];
  assign output_invert = timer_control_1[B_INV];
  assign pwm_role_swap = timer_control_1[B_SWAP];
  assign clear_source_select = timer_control_1[B_CLRSEL];
  // ==========================================================
  // counting clock
  logic tick;
  count_tick_gen u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .clock_select(clock_select),
    .high_clk_tick(high_clk_tick),
    .sub_clk_tick(sub_clk_tick),
    .external_count_clock_pin(external_count_clock_pin),
    .tick(tick)
  );
  // ==========================================================
  // comparators
  logic on_rise;
  logic run_tick;
  logic pwm_mode;
  logic [CNT_W-1:0] next_count;
  logic p_hit;
  logic a_hit;
  logic clear_hit;
  logic [CNT_W-1:0] duty_value;
  logic pwm_active;
  assign pwm_mode = (operating_mode_select == MODE_PWM);
  assign on_rise = counter_on && !on_q; // RULE6
  assign run_tick = tick && counter_on && !pause_ctl && !on_rise; // RULE4
  assign next_count = count + 10'h001; // RULE1
  // period zero matches at overflow, giving 1024 clocks
  assign p_hit = (period_compare_value != 3'h0) ?
      (next_count == {period_compare_value, 7'h00}) :
      (count == CNT_MAX); // RULE2 RULE8 RULE9
  assign a_hit = (compare_a_value != 10'h000) &&
      (next_count == compare_a_value); // RULE2
  assign clear_hit = pwm_mode ? (pwm_role_swap ? a_hit : p_hit) :
      (clear_source_select ? a_hit : p_hit); // RULE20 RULE21
  assign duty_value = pwm_role_swap ? {period_compare_value, 7'h00} :
      compare_a_value; // RULE21
  assign pwm_active = (count < duty_value);
  // ==========================================================
  // counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 10'h000;
      on_q <= 1'b0;
    end else begin
      on_q <= counter_on;
      if (on_rise) begin
        count <= 10'h000; // RULE3 RULE6
      end else if (run_tick) begin
        count <= clear_hit ? 10'h000 : next_count; // RULE1 RULE3 RULE9
      end
    end
  end
  // ==========================================================
  // match events
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_a <= 1'b0;
      event_p <= 1'b0;
    end else begin
      event_a <= run_tick && a_hit; // RULE24
      event_p <= run_tick && p_hit &&
          (pwm_mode || !clear_source_select); // RULE24 RULE20
    end
  end
  // ==========================================================
  // output pins
  output_shaper u_out (
    .aclk(aclk),
    .aresetn(aresetn),
    .operating_mode_select(operating_mode_select), // RULE10
    .output_function_select(output_function_select),
    .output_initial_level(output_initial_level),
    .output_invert(output_invert),
    .on_rise(on_rise),
    .a_match(run_tick && a_hit),
    .pwm_active(pwm_active),
    .timer_output_pin(timer_output_pin),
    .timer_output_pin_inverted(timer_output_pin_inverted)
  );
  // ==========================================================
  // axi write channels
  logic wr_fire;
  logic wr_mapped;
  assign wr_fire = aw_hold && w_hold && !bvalid;
  always_comb begin
    unique case (aw_addr_q)
      OFS_CTL0, OFS_CTL1, OFS_CNT_LOW, OFS_CNT_HIGH,
      OFS_CMPA_LOW, OFS_CMPA_HIGH: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      awready <= 1'b1;
      aw_addr_q <= 8'h00;
    end else if (awvalid && awready) begin
      aw_hold <= 1'b1;
      awready <= 1'b0;
      aw_addr_q <= awaddr;
    end else if (wr_fire) begin
      aw_hold <= 1'b0;
      awready <= 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold <= 1'b0;
      wready <= 1'b1;
      w_byte_q <= 8'h00;
      w_lane_q <= 1'b0;
    end else if (wvalid && wready) begin
      w_hold <= 1'b1;
      wready <= 1'b0;
      w_byte_q <= wdata[7:0];
      w_lane_q <= wstrb[0];
    end else if (wr_fire) begin
      w_hold <= 1'b0;
      wready <= 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end
  // ==========================================================
  // register writes
  logic wr_en;
  assign wr_en = wr_fire && w_lane_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_control_0 <= RST_CTL0;
      timer_control_1 <= RST_CTL1;
      compare_a_value <= RST_CMPA;
    end else if (wr_en) begin
      if (aw_addr_q == OFS_CTL0) begin
        timer_control_0 <= w_byte_q;
      end
      if (aw_addr_q == OFS_CTL1) begin
        timer_control_1 <= w_byte_q;
      end
      if (aw_addr_q == OFS_CMPA_HIGH) begin
        compare_a_value <= {w_byte_q[1:0], byte_buffer}; // RULE19 RULE23
      end
    end
  end
  // ==========================================================
  // axi read channels
  logic rd_take;
  logic [7:0] rd_byte;
  logic rd_mapped;
  assign rd_take = arvalid && arready;
  always_comb begin
    rd_byte = 8'h00;
    rd_mapped = 1'b1;
    unique case (araddr)
      OFS_CTL0: rd_byte = timer_control_0;
      OFS_CTL1: rd_byte = timer_control_1;
      OFS_CNT_LOW, OFS_CMPA_LOW: rd_byte = byte_buffer; // RULE23
      OFS_CNT_HIGH: rd_byte = {6'h00, count[9:8]}; // RULE19
      OFS_CMPA_HIGH: rd_byte = {6'h00, compare_a_value[9:8]}; // RULE19
      default: rd_mapped = 1'b0;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else if (rd_take) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h000000, rd_byte};
      rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end
  // ==========================================================
  // shared low-byte buffer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      byte_buffer <= 8'h00;
    end else if (rd_take && araddr == OFS_CNT_HIGH) begin
      byte_buffer <= count[7:0]; // RULE23
    end else if (rd_take && araddr == OFS_CMPA_HIGH) begin
      byte_buffer <= compare_a_value[7:0]; // RULE23
    end else if (wr_en && aw_addr_q == OFS_CMPA_LOW) begin
      byte_buffer <= w_byte_q; // RULE23
    end
  end
  // ==========================================================
  // assertions
  property p_step;
    @(posedge aclk) disable iff (!aresetn)
    run_tick && !clear_hit |=> count == $past(count) + 10'h001;
  endproperty
  AST_COUNT_STEP: assert property (p_step) // RULE1
    else $error("counter did not advance by one");
  AST_PAUSE_HOLD: assert property ( // RULE4
    @(posedge aclk) disable iff (!aresetn)
    pause_ctl && !on_rise |=> $stable(count))
    else $error("counter moved while paused");
  AST_OFF_HOLD: assert property ( // RULE6
    @(posedge aclk) disable iff (!aresetn)
    !counter_on |=> $stable(count))
    else $error("counter moved while off");
  AST_ON_CLEAR: assert property ( // RULE3
    @(posedge aclk) disable iff (!aresetn)
    on_rise |=> count == 10'h000)
    else $error("on rising edge did not clear counter");
  AST_P_CLEAR: assert property ( // RULE9
    @(posedge aclk) disable iff (!aresetn)
    run_tick && p_hit && !clear_source_select && !pwm_mode
    |=> count == 10'h000 && event_p ##1 !event_p)
    else $error("period match did not clear counter");
  AST_A_CLEAR: assert property ( // RULE20
    @(posedge aclk) disable iff (!aresetn)
    run_tick && a_hit && clear_source_select && !pwm_mode
    |=> count == 10'h000 && event_a && !event_p)
    else $error("compare A match clear or events wrong");
  AST_INV_PIN: assert property ( // RULE18
    @(posedge aclk) disable iff (!aresetn)
    timer_output_pin_inverted == !timer_output_pin)
    else $error("inverted pin not the inverse");
  AST_RESTORE: assert property ( // RULE7
    @(posedge aclk) disable iff (!aresetn)
    on_rise && operating_mode_select == MODE_CMP
    |=> timer_output_pin == ($past(output_initial_level) ^
        $past(output_invert)))
    else $error("output pin not restored on start");
  AST_SET_HIGH: assert property ( // RULE13
    @(posedge aclk) disable iff (!aresetn)
    run_tick && a_hit && operating_mode_select == MODE_CMP &&
    output_function_select == IO_HIGH
    |=> timer_output_pin == !$past(output_invert))
    else $error("drive high match action failed");
  AST_PERIOD_WRAP: assert property ( // RULE8
    @(posedge aclk) disable iff (!aresetn)
    run_tick && period_compare_value == 3'h1 && !pwm_mode &&
    !clear_source_select && count == 10'h07F |=> count == 10'h000)
    else $error("period of 128 not honoured");
  AST_HIGH_READ: assert property ( // RULE23
    @(posedge aclk) disable iff (!aresetn)
    rd_take && araddr == OFS_CNT_HIGH
    |=> byte_buffer == $past(count[7:0]))
    else $error("high read did not capture low byte");
  COV_A_MATCH: cover property (@(posedge aclk) event_a);
  COV_P_MATCH: cover property (@(posedge aclk) event_p);
  COV_PWM_EDGE: cover property (@(posedge aclk)
    pwm_mode && $rose(timer_output_pin));
  COV_CMPA_WRITE: cover property (@(posedge aclk)
    wr_en && aw_addr_q == OFS_CMPA_HIGH);
endmodule : compact_timer
`default_nettype wire

// ===== tb/ext_clock_partner.sv
// Purpose: far-side model of the clock sources and count pin
// Assumes: all outputs change just after an aclk rising edge
// Notes: the count pin stays low except while pulses are requested
`timescale 1ns/1ps
`default_nettype none
module ext_clock_partner (
  // clock
  input wire logic aclk,
  // sources
  output logic high_clk_tick,
  output logic sub_clk_tick,
  output var logic external_count_clock_pin
);
  logic [2:0] div = 3'h0;
  initial external_count_clock_pin = 1'b0;
  always @(posedge aclk) div <= div + 3'h1;
  assign high_clk_tick = div[0];
  assign sub_clk_tick = (div == 3'h0);
  // ==========================================================
  // count pin pulses, two cycles high and two low
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge aclk);
      external_count_clock_pin <= 1'b1;
      repeat (2) @(posedge aclk);
      external_count_clock_pin <= 1'b0;
      @(posedge aclk);
    end
    repeat (3) @(posedge aclk);
  endtask : pulse
endmodule : ext_clock_partner
`default_nettype wire

// ===== tb/compact_timer_tb.sv
// Purpose: self-checking bench for the compact timer
// Assumes: register access over AXI4-Lite, one write or read at a time
// Notes: counts come from pin pulses so expected values are exact
`timescale 1ns/1ps
`default_nettype none
module compact_timer_tb;
  import compact_timer_pkg::*;
  logic aclk = 1'b0, aresetn;
  logic awvalid, wvalid, bready;
  logic arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, d;
  logic high_clk_tick, sub_clk_tick, external_count_clock_pin;
  logic timer_output_pin, timer_output_pin_inverted, event_a, event_p;
  int errors = 0, cmp_count = 0, cyc = 0, ev_a = 0, ev_p = 0;
  logic [7:0] offs [3] = '{OFS_CTL0, OFS_CTL1, OFS_CMPA_HIGH};
  compact_timer compact_timer_i (.aclk, .aresetn, .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
    .high_clk_tick, .sub_clk_tick, .external_count_clock_pin,
    .timer_output_pin, .timer_output_pin_inverted, .event_a, .event_p);
  ext_clock_partner partner_i (.aclk, .high_clk_tick, .sub_clk_tick,
    .external_count_clock_pin);
  always #5 aclk = ~aclk;
  // ==========================================================
  // event counting and watchdog
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    ev_a <= ev_a + (event_a === 1'b1);
    ev_p <= ev_p + (event_p === 1'b1);
    if (cyc == 20000) begin
      errors = errors + 1;
      close_out();
    end
  end
  // ==========================================================
  // helpers
  task automatic close_out();
    if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= {24'h000000, v};
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    resp = rresp;
  endtask : rd
  task automatic cnt(input logic [9:0] exp);
    rd(OFS_CNT_HIGH);
    chk(d, {30'h0, exp[9:8]});
    rd(OFS_CNT_LOW);
    chk(d, {24'h0, exp[7:0]});
  endtask : cnt
  task automatic pins(input logic v);
    chk(timer_output_pin, v);
    chk(timer_output_pin_inverted, !v);
  endtask : pins
  task automatic swap_cfg(input logic [7:0] c1, input logic [7:0] c0);
    wr(OFS_CTL0, c0 & 8'hF7);
    wr(OFS_CTL1, c1);
    wr(OFS_CTL0, c0);
  endtask : swap_cfg
  // ==========================================================
  // main sequence
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr} = 16'h0000;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rd(offs[i]);
      chk(d, 32'h0);
    end
    rd(8'h18);
    chk(resp, RESP_SLVERR);
    wr(8'h18, 8'h00);
    chk(resp, RESP_SLVERR);
    pins(1'b0);
    wr(OFS_CMPA_LOW, 8'h34);
    wr(OFS_CMPA_HIGH, 8'h02);
    rd(OFS_CMPA_HIGH);
    chk(d, 32'h2);
    rd(OFS_CMPA_LOW);
    chk(d, 32'h34);
    wstrb <= 4'h0;
    wr(OFS_CTL1, 8'hFF);
    wstrb <= 4'hF;
    rd(OFS_CTL1);
    chk(d, 32'h0);
    wr(OFS_CNT_HIGH, 8'h03);
    chk(resp, RESP_OKAY);
    cnt(10'h000);
    wr(OFS_CMPA_LOW, 8'h05);
    wr(OFS_CMPA_HIGH, 8'h00);
    swap_cfg(8'h21, 8'h68);
    partner_i.pulse(3);
    cnt(10'h003);
    pins(1'b0);
    partner_i.pulse(2);
    cnt(10'h000);
    pins(1'b1);
    chk(ev_a, 1);
    chk(ev_p, 0);
    wr(OFS_CTL0, 8'hE8);
    partner_i.pulse(3);
    cnt(10'h000);
    wr(OFS_CTL0, 8'h68);
    partner_i.pulse(2);
    cnt(10'h002);
    wr(OFS_CTL0, 8'h60);
    partner_i.pulse(2);
    cnt(10'h002);
    wr(OFS_CTL0, 8'h68);
    cnt(10'h000);
    pins(1'b0);
    swap_cfg(8'h35, 8'h68);
    @(posedge aclk);
    pins(1'b1);
    partner_i.pulse(5);
    pins(1'b0);
    partner_i.pulse(5);
    pins(1'b1);
    swap_cfg(8'h11, 8'h68);
    partner_i.pulse(5);
    pins(1'b0);
    swap_cfg(8'h00, 8'h69);
    partner_i.pulse(127);
    cnt(10'h07F);
    chk(ev_a, 5);
    partner_i.pulse(1);
    cnt(10'h000);
    chk(ev_p, 1);
    swap_cfg(8'hA8, 8'h79);
    partner_i.pulse(2);
    pins(1'b1);
    partner_i.pulse(5);
    pins(1'b0);
    swap_cfg(8'hAA, 8'h79);
    partner_i.pulse(7);
    cnt(10'h002);
    pins(1'b1);
    swap_cfg(8'h00, 8'h01);
    for (int k = 0; k < 6; k++) begin
      wr(OFS_CTL0, 8'h01);
      wr(OFS_CTL0, {1'b0, 3'(k), 4'h9});
      repeat (300) @(posedge aclk);
      wr(OFS_CTL0, 8'h01);
      rd(OFS_CNT_HIGH);
      rd(OFS_CNT_LOW);
      chk(d != 32'h0, 32'h1);
    end
    close_out();
  end
endmodule : compact_timer_tb
`default_nettype wire
